// ==== core/eav_pkg.sv ====
// Purpose: Constants for the exception arbiter and vector logic
// Assumes: 21 maskable sources, 16-bit vector space, APB data 32 bits
// Notes: Flag n sits at source index n-1; index 0 has top priority
package eav_pkg;
   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int EAV_NSRC = 21;
   localparam int EAV_IDXW = 5;
   // -------------------------------------------------------------
   // Register byte addresses (APB, one word each)
   // -------------------------------------------------------------
   localparam logic [15:0] EAV_ADDR_FLAGS_LOW = 16'hFE04;
   localparam logic [15:0] EAV_ADDR_FLAGS_MID = 16'hFE08;
   localparam logic [15:0] EAV_ADDR_FLAGS_HIGH = 16'hFE0C;
   localparam logic [15:0] EAV_ADDR_ENABLE = 16'hFE10;
   localparam logic [15:0] EAV_ADDR_STATUS = 16'hFE14;
   localparam logic [7:0] EAV_FLAGS_RESET = 8'h00;
   // -------------------------------------------------------------
   // Field layout
   // -------------------------------------------------------------
   localparam int EAV_LOW_LSB = 2;   // Flags 6..1 at bits 7..2
   localparam int EAV_LOW_N = 6;
   localparam int EAV_MID_BASE = 6;  // Flags 14..7
   localparam int EAV_MID_N = 8;
   localparam int EAV_HIGH_BASE = 14; // Flags 21..15
   localparam int EAV_HIGH_N = 7;
   // -------------------------------------------------------------
   // Vectors
   // -------------------------------------------------------------
   localparam logic [15:0] EAV_VEC_RESET = 16'hFFFE;
   localparam logic [15:0] EAV_VEC_TRAP = 16'hFFFC;
   localparam logic [15:0] EAV_VEC_SRC0 = 16'hFFFA;
   localparam logic [15:0] EAV_VEC_RSVD = 16'hFFD0;
   localparam logic [15:0] EAV_VEC_STEP = 16'h0002;
   // Arbitration constant codes
   localparam logic [4:0] EAV_CODE_TRAP = 5'h1E;
   localparam logic [4:0] EAV_CODE_RESET = 5'h1F;
   localparam logic [4:0] EAV_CODE_NONE = 5'h1D;
   localparam logic [31:0] EAV_ENABLE_RESET = 32'h001FFFFF;
   localparam logic [31:0] EAV_ZERO = 32'h00000000;
   typedef enum logic [3:0] {
      EAV_IDLE = 4'h1,
      EAV_LATCHED = 4'h2,
      EAV_STACK = 4'h4,
      EAV_SERVICE = 4'h8
   } eav_state_t;
endpackage

// ==== core/eav_prio_enc.sv ====
// Purpose: Fixed priority encoder, lowest index wins
// Assumes: Request vector of NSRC bits
// Notes: Purely combinational
`timescale 1ns/1ps
module eav_prio_enc import eav_pkg::*; #(
   parameter int NSRC = EAV_NSRC
) (
   input wire logic [NSRC-1:0] req,
   output logic any,
   output logic [EAV_IDXW-1:0] idx
);
   initial begin
      if (NSRC < 1 || NSRC > 29) begin
         $error("eav_prio_enc: NSRC out of range");
      end
   end
   // Scan from lowest priority upward so the top source is last word
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = EAV_IDXW'(i);
         end
      end
   end
endmodule

// ==== core/eav_top.sv ====
// Purpose: Exception arbiter and vector selector beside the CPU core
// Assumes: CPU pulses instr_done at each instruction boundary
// Notes: APB slave holds flag, enable and status registers
//
// Notes on behaviour
// R1: Only interrupts, trap, reset, break divert flow
// R2: Entry stacks registers and sets mask flag; a reset entry here sets the mask without stacking
// R3: Return-from-trap restores stacked registers
// R4: Latch and arbitrate, output vector select constant
// R5: Latched request holds until served or unmasked
// R6: Hardware interrupts wait for instruction completion
// R7: Check pending at boundary: mask clear, enabled
// R8: Highest priority pending request served first
// R9: Pending request served right after return
// R10: Entry never stacks the high index register
// R11: Software trap ignores the mask flag
// R12: Trap stacks PC, hardware stacks PC minus one
// R13: Low flag register: flags six..one, bits 7..2
// R14: Mid and high registers report remaining flags
// R15: Each source fixed two-byte vector, fixed priority
// R16: Line one highest maskable, timebase lowest
// R17: Resets equal, highest, never arbitrated
// R18: Break forces the software trap vector
// R19: Lower vector byte high, higher byte low
// R20: Flags track request lines continuously
`timescale 1ns/1ps
module eav_top import eav_pkg::*; #(
   parameter int NSRC = EAV_NSRC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NSRC-1:0] irq_req,
   input wire logic instr_done,
   input wire logic trap_exec,
   input wire logic return_exec,
   input wire logic break_req,
   input wire logic reset_req,
   input wire logic mask_flag,
   input wire logic [1:0] vec_byte_sel,
   output logic take_exception,
   output logic [EAV_IDXW-1:0] vector_code,
   output logic [15:0] vector_addr,
   output logic stack_pc_minus_one,
   output logic stack_regs,
   output logic stack_high_index,
   output logic set_mask,
   output logic restore_regs
);
   initial begin
      if (NSRC != EAV_NSRC) begin
         $error("eav_top: flag map needs NSRC of 21");
      end
   end
   // -------------------------------------------------------------
   // Request flags and enables
   // -------------------------------------------------------------
   logic [NSRC-1:0] flags;
   logic [NSRC-1:0] enables;
   logic [NSRC-1:0] eligible;
   logic hw_any;
   logic [EAV_IDXW-1:0] hw_idx;
   eav_state_t state;
   eav_state_t next_state;
   logic [EAV_IDXW-1:0] latched_code;
   logic latched_hw;
   // Flags follow the lines, regardless of mask or enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else begin
         flags <= irq_req; // R20 R14
      end
   end
   assign eligible = flags & enables; // R7
   // Lowest index is flag one, the highest maskable source
   eav_prio_enc #(.NSRC(NSRC)) u_prio (
      .req(eligible),
      .any(hw_any),
      .idx(hw_idx)
   ); // R8 R16
   // -------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------
   function automatic logic [15:0] code_to_vec(input logic [4:0] code);
      logic [15:0] v;
      v = EAV_VEC_RSVD;
      if (code == EAV_CODE_RESET) begin
         v = EAV_VEC_RESET;
      end else if (code == EAV_CODE_TRAP) begin
         v = EAV_VEC_TRAP;
      end else if (code < 5'(EAV_NSRC)) begin
         v = EAV_VEC_SRC0 - 16'({11'h000, code} << 1); // R15
      end
      return v;
   endfunction
   function automatic logic is_addr(input logic [15:0] a,
                                    input logic [15:0] b);
      return a == b;
   endfunction
   // -------------------------------------------------------------
   // Exception sequencer
   // -------------------------------------------------------------
   logic trap_like;
   logic hw_go;
   assign trap_like = trap_exec | break_req; // R11 R18
   assign hw_go = hw_any & ~mask_flag & instr_done; // R6 R7
   always_comb begin
      next_state = state;
      case (state)
         EAV_IDLE: begin
            if (reset_req || trap_like || hw_go) begin
               next_state = EAV_LATCHED; // R1
            end
         end
         EAV_LATCHED: begin
            next_state = EAV_STACK;
         end
         EAV_STACK: begin
            next_state = EAV_SERVICE;
         end
         EAV_SERVICE: begin
            // Return reopens arbitration from the next cycle, back in EAV_IDLE
            if (return_exec || reset_req) begin
               next_state = EAV_IDLE; // R9
            end
         end
         default: begin
            next_state = EAV_IDLE;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= EAV_IDLE;
      end else begin
         state <= next_state;
      end
   end
   // Latch the winner; only a later reset request can displace it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_code <= EAV_CODE_NONE;
         latched_hw <= 1'b0;
      end else if (reset_req) begin
         latched_code <= EAV_CODE_RESET; // R17
         latched_hw <= 1'b0;
      end else if (state == EAV_IDLE) begin
         if (trap_like) begin
            latched_code <= EAV_CODE_TRAP; // R11 R18
            latched_hw <= 1'b0;
         end else if (hw_go) begin
            latched_code <= hw_idx; // R4 R5
            latched_hw <= 1'b1;
         end
      end else if (state == EAV_LATCHED && latched_hw && mask_flag == 1'b0
                   && !eligible[latched_code]) begin
         // Held request stays latched even after its line goes idle
         latched_code <= latched_code; // R5
      end
   end
   // Outputs to the CPU core, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         take_exception <= 1'b0;
         vector_code <= EAV_CODE_NONE;
         stack_pc_minus_one <= 1'b0;
         stack_regs <= 1'b0;
         stack_high_index <= 1'b0;
         set_mask <= 1'b0;
         restore_regs <= 1'b0;
      end else begin
         take_exception <= (state == EAV_LATCHED); // R4
         vector_code <= latched_code; // R4
         stack_pc_minus_one <= (state == EAV_LATCHED) && latched_hw; // R12
         // Reset does not stack; everything else does
         stack_regs <= (state == EAV_LATCHED)
                       && (latched_code != EAV_CODE_RESET); // R2
         stack_high_index <= 1'b0; // R10
         set_mask <= (state == EAV_STACK); // R2
         restore_regs <= (state == EAV_SERVICE) && return_exec; // R3
      end
   end
   // Vector byte: sel 0 gives high address byte, sel 1 low byte
   logic [15:0] vec_base;
   assign vec_base = code_to_vec(latched_code);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_addr <= EAV_VEC_RESET;
      end else begin
         vector_addr <= vec_base + {15'h0000, vec_byte_sel[0]}; // R19
      end
   end
   // -------------------------------------------------------------
   // APB register slave, zero wait states
   // -------------------------------------------------------------
   logic apb_wr;
   logic apb_rd;
   logic [31:0] rd_mux;
   // Flag n lands at bit n+1 of the low register; bits 1..0 read zero
   logic [7:0] low_byte;
   logic [7:0] mid_byte;
   logic [7:0] high_byte;
   logic addr_ok;
   // Writes land in the access phase, where pready is high
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & ~penable & ~pwrite;
   assign low_byte = {flags[EAV_LOW_N-1:0], 2'b00} ; // R13
   // Bit order puts the higher flag number in the higher bit
   always_comb begin
      mid_byte = EAV_FLAGS_RESET;
      high_byte = EAV_FLAGS_RESET;
      for (int i = 0; i < EAV_MID_N; i++) begin
         mid_byte[i] = flags[EAV_MID_BASE + i]; // R14
      end
      for (int i = 0; i < EAV_HIGH_N; i++) begin
         high_byte[i] = flags[EAV_HIGH_BASE + i]; // R14
      end
   end
   always_comb begin
      rd_mux = EAV_ZERO;
      addr_ok = 1'b1;
      if (is_addr(paddr, EAV_ADDR_FLAGS_LOW)) begin
         rd_mux = {24'h000000, low_byte}; // R13
      end else if (is_addr(paddr, EAV_ADDR_FLAGS_MID)) begin
         rd_mux = {24'h000000, mid_byte};
      end else if (is_addr(paddr, EAV_ADDR_FLAGS_HIGH)) begin
         rd_mux = {24'h000000, high_byte};
      end else if (is_addr(paddr, EAV_ADDR_ENABLE)) begin
         rd_mux = {11'h000, enables};
      end else if (is_addr(paddr, EAV_ADDR_STATUS)) begin
         rd_mux = {23'h000000, latched_hw, state, latched_code[3:0]};
      end else begin
         addr_ok = 1'b0;
      end
   end
   // Enables: the only writable register; steers arbitration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enables <= EAV_ENABLE_RESET[NSRC-1:0];
      end else if (apb_wr && is_addr(paddr, EAV_ADDR_ENABLE)) begin
         enables <= pwdata[NSRC-1:0];
      end
   end
   // Read data and error registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= EAV_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (apb_rd) begin
            prdata <= rd_mux;
         end
      end
   end
endmodule

// ==== sim/eav_assertions.sv ====
// Purpose: Port checker for the exception arbiter
// Assumes: One pclk domain, presetn async active low
// Notes: Entry comes two edges after detection; the boundary and cause checks also accept three
`timescale 1ns/1ps
module eav_chk import eav_pkg::*; #(
   parameter int NSRC = EAV_NSRC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic instr_done,
   input wire logic trap_exec,
   input wire logic return_exec,
   input wire logic break_req,
   input wire logic mask_flag,
   input wire logic take_exception,
   input wire logic [EAV_IDXW-1:0] vector_code,
   input wire logic stack_pc_minus_one,
   input wire logic stack_regs,
   input wire logic stack_high_index,
   input wire logic set_mask,
   input wire logic restore_regs
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Hardware entry only after an unmasked instruction boundary
   wire hw_take = take_exception && vector_code < NSRC;
   wire trap_take = take_exception && vector_code == EAV_CODE_TRAP;
   hi_index_a: assert property (!stack_high_index)
      else $error("high index register stacked");
   on_boundary_a: assert property (hw_take |->
      $past(instr_done, 2) || $past(instr_done, 3))
      else $error("hardware entry off a boundary");
   when_unmasked_a: assert property (hw_take |-> !$past(mask_flag, 2))
      else $error("hardware entry while masked");
   pc_kind_a: assert property (take_exception |->
      stack_pc_minus_one == (vector_code < NSRC))
      else $error("wrong stacked pc kind");
   trap_cause_a: assert property (trap_take |->
      $past(trap_exec | break_req, 2) || $past(trap_exec | break_req, 3))
      else $error("trap vector without cause");
   stack_then_mask_a: assert property (take_exception &&
      vector_code != EAV_CODE_RESET |-> stack_regs ##1 set_mask)
      else $error("entry without stacking and mask");
   restore_cause_a: assert property (restore_regs |-> $past(return_exec))
      else $error("restore without return");
   single_entry_a: assert property (take_exception |=>
      !take_exception [*2])
      else $error("entry pulse repeated");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   cover property (hw_take);
   cover property (trap_take);
   cover property (restore_regs);
endmodule
bind eav_top eav_chk #(.NSRC(NSRC)) chk (.pclk, .presetn, .psel, .penable,
   .pready, .instr_done, .trap_exec, .return_exec, .break_req, .mask_flag,
   .take_exception, .vector_code, .stack_pc_minus_one, .stack_regs,
   .stack_high_index, .set_mask, .restore_regs);

// ==== sim/eav_cpu_model.sv ====
// Purpose: CPU core stand-in beside the exception arbiter
// Assumes: Same pclk and presetn as the arbiter
// Notes: Service length from the bench, prompt or slow
`timescale 1ns/1ps
module eav_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic take_exception,
   input wire logic set_mask,
   input wire logic restore_regs,
   input wire logic clear_mask,
   input wire logic [3:0] svc_len,
   output logic instr_done,
   output logic return_exec,
   output logic mask_flag
);
   // ------------------------------------------------------------
   // Core behaviour
   // ------------------------------------------------------------
   logic [3:0] cnt;
   logic [3:0] sc;
   logic busy;
   logic saved;
   // Boundary every fourth cycle, none while in a routine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         instr_done <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
         instr_done <= !busy && cnt[1:0] == 2'h3;
      end
   end
   // Routine runs svc_len cycles, then one return pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         sc <= 4'h0;
         return_exec <= 1'b0;
      end else begin
         return_exec <= busy && sc == 4'h1;
         if (take_exception) begin
            busy <= 1'b1;
            sc <= svc_len;
         end else if (restore_regs) begin
            busy <= 1'b0;
         end else if (busy && sc != 4'h0) begin
            sc <= sc - 4'h1;
         end
      end
   end
   // Mask set on reset and entry; return puts back the old value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_flag <= 1'b1;
         saved <= 1'b1;
      end else begin
         if (take_exception) saved <= mask_flag;
         if (set_mask) mask_flag <= 1'b1;
         else if (restore_regs) mask_flag <= saved;
         else if (clear_mask) mask_flag <= 1'b0;
      end
   end
endmodule

// ==== sim/eav_top_tb.sv ====
// Purpose: Self-checking bench for the exception arbiter
// Assumes: 200 MHz pclk, APB master tasks below
// Notes: Random requests from a fixed xorshift seed
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   err_total++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module eav_top_tb import eav_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, got;
   logic [15:0] paddr, vector_addr;
   logic [31:0] pwdata, prdata, q, r, seed = 32'h0000FE61;
   logic [20:0] irq_req, rem, en;
   logic instr_done, trap_exec, return_exec, break_req, reset_req;
   logic mask_flag, clear_mask, take_exception, stack_pc_minus_one;
   logic stack_regs, stack_high_index, set_mask, restore_regs;
   logic [1:0] vec_byte_sel;
   logic [4:0] vector_code, e;
   logic [3:0] svc_len;
   int err_total, check_count, n;
   eav_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq_req, .instr_done, .trap_exec,
      .return_exec, .break_req, .reset_req, .mask_flag, .vec_byte_sel,
      .take_exception, .vector_code, .vector_addr, .stack_pc_minus_one,
      .stack_regs, .stack_high_index, .set_mask, .restore_regs);
   eav_cpu_model cpu (.pclk, .presetn, .take_exception, .set_mask,
      .restore_regs, .clear_mask, .svc_len, .instr_done, .return_exec,
      .mask_flag);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [4:0] prio(input logic [20:0] v);
      for (int i = 0; i < 21; i++) if (v[i]) return i[4:0];
      return EAV_CODE_NONE;
   endfunction
   // Flag n of the low register sits at bit n+1
   function automatic logic [31:0] flg(input logic [20:0] v, input int k);
      logic [31:0] f;
      f = '0;
      for (int i = 0; i < 8; i++) begin
         if (k == 0 && i < 6) f[2+i] = v[i];
         if (k == 1) f[i] = v[6+i];
         if (k == 2 && i < 7) f[i] = v[14+i];
      end
      return f;
   endfunction
   function automatic logic [15:0] va(input logic [4:0] c, input logic s);
      if (c == EAV_CODE_RESET) return EAV_VEC_RESET + 16'(s);
      if (c == EAV_CODE_TRAP) return EAV_VEC_TRAP + 16'(s);
      return EAV_VEC_SRC0 - EAV_VEC_STEP * 16'(c) + 16'(s);
   endfunction
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let one edge pass so a following call never reassigns psel
      @(posedge pclk);
   endtask
   task wt(input int lim);
      got = 1'b0;
      n = 0;
      while (!got && n < lim) begin
         @(posedge pclk);
         got = take_exception === 1'b1;
         n++;
      end
   endtask
   // One entry: code, stacked pc kind, vector byte, then wait for return
   task tk(input logic [4:0] c, input logic pm);
      wt(40);
      `CHK("taken", 1'b1, got)
      `CHK("code", c, vector_code)
      `CHK("pc_minus_one", pm, stack_pc_minus_one)
      repeat (2) @(posedge pclk);
      `CHK("vector_addr", va(c, vec_byte_sel[0]), vector_addr)
      n = 0;
      do begin @(posedge pclk); n++; end
         while (restore_regs !== 1'b1 && n < 80);
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      summarize();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, trap_exec, break_req, reset_req} = '0;
      {paddr, pwdata, irq_req, vec_byte_sel, clear_mask} = '0;
      svc_len = 4'hF;
      presetn = 1'b0;
      // Reset values are looked at while reset still holds them
      repeat (5) @(posedge pclk);
      #1;
      `CHK("reset_code", EAV_CODE_NONE, vector_code)
      `CHK("reset_vaddr", EAV_VEC_RESET, vector_addr)
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, EAV_ADDR_FLAGS_LOW, 32'hFFFFFFFF);
      apb(1'b0, EAV_ADDR_FLAGS_LOW, '0);
      `CHK("flags_low", 32'h0, q)
      apb(1'b0, 16'hFE40, '0);
      `CHK("slverr", 1'b1, slv)
      $display("test reset done");
      // Masked after reset, so flags show requests with no entry
      for (int i = 0; i < 8; i++) begin
         r = (i == 0) ? 32'h001FFFFF : rnd();
         irq_req <= r[20:0];
         repeat (2) @(posedge pclk);
         for (int k = 0; k < 3; k++) begin
            apb(1'b0, EAV_ADDR_FLAGS_LOW + 16'(4 * k), '0);
            `CHK("flags", flg(irq_req, k), q)
         end
      end
      $display("test flags done");
      // Trap then break while masked, slow service
      for (int j = 0; j < 2; j++) begin
         vec_byte_sel <= 2'(j);
         if (j == 0) trap_exec <= 1'b1;
         else break_req <= 1'b1;
         @(posedge pclk);
         trap_exec <= 1'b0;
         break_req <= 1'b0;
         tk(EAV_CODE_TRAP, 1'b0);
      end
      $display("test trap done");
      // Unmask with random requests and enables, prompt service
      svc_len <= 4'h2;
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         en = (i % 3 == 2) ? r[31:11] : 21'h1FFFFF;
         if (i == 0) r[20:0] = 21'h100000;
         apb(1'b1, EAV_ADDR_ENABLE, {11'h0, en});
         irq_req <= r[20:0];
         vec_byte_sel <= r[22:21];
         clear_mask <= 1'b1;
         @(posedge pclk);
         clear_mask <= 1'b0;
         rem = r[20:0] & en;
         while (rem != '0) begin
            e = prio(rem);
            tk(e, 1'b1);
            rem[e] = 1'b0;
            irq_req <= irq_req & ~(21'h1 << e);
         end
         wt(30);
         `CHK("idle", 1'b0, got)
         irq_req <= '0;
      end
      $display("test arbitration done");
      reset_req <= 1'b1;
      @(posedge pclk);
      reset_req <= 1'b0;
      wt(20);
      `CHK("reset_req_code", EAV_CODE_RESET, vector_code)
      `CHK("reset_no_stack", 1'b0, stack_regs)
      $display("test reset request done");
      summarize();
   end
endmodule
